// ==== core/arc_defs.vh ====
// Purpose: shared constants of the analog reference conditioner
// Assumes: 16-bit signed samples, +full scale = 10 V / 20 mA = 16'h7FFF
// Notes: frequencies in 0.01 Hz, percentages in 0.1 %, filter time in ms
//
// Overview of operation
// - Channel characteristic codes 0-6, 0-5, 0-6
// - Linear scaling per code, forward or reversed
// - Code 6 bipolar, enables joystick mode
// - Channels one, three bipolar; two unipolar
// - Programmable low-pass filter on all channels
// - Main selector routes channel one, two, three
// - Auxiliary selector: off, channel two, three
// - Auxiliary trim added to main input
// - Auxiliary bipolar around range centre, percent limited
// - Auxiliary trim linear in its input
// - Setting modes 7, 8 force absolute inputs
// - Auxiliary input taken as absolute value
// - Tachogenerator closed loop forces absolute inputs
// - Joystick input sign sets direction, disables auxiliary, sets band
// - Dead band gives zero, edge maps linearly
// - Feedback value serves only the regulator
// - Feedback codes 0-3: two, three, sum, difference
// - Codes 4, 5: scaled product and quotient
// - Codes 6, 7: minimum and maximum
// - Codes 8, 9: square root forms
// - Feedback absolute, clamped to highest analog value
`ifndef ARC_DEFS_VH
`define ARC_DEFS_VH
`define ARC_FULL_SCALE 16'h7FFF
`define ARC_HALF_SCALE 16'h3FFF
`define ARC_OFFSET_FLOOR 18'h0199A
`define ARC_FRAC_MAX 18'h0FFFF
`define ARC_FRAC_MID 18'h08000
`define ARC_PERMILLE_MUL 56'sh0000000000419
`define ARC_PERMILLE_SHIFT 20
`define ARC_PERMILLE_DIV 32'h000003E8
`define ARC_CODE_FULL_FWD 3'h0
`define ARC_CODE_HALF_FWD 3'h1
`define ARC_CODE_FULL_REV 3'h2
`define ARC_CODE_HALF_REV 3'h3
`define ARC_CODE_OFS_FWD 3'h4
`define ARC_CODE_OFS_REV 3'h5
`define ARC_CODE_BIPOLAR 3'h6
`define ARC_MODE_ABS_A 4'h7
`define ARC_MODE_ABS_B 4'h8
`define ARC_SEL_NONE 2'h0
`define ARC_SEL_TWO 2'h1
`define ARC_SEL_THREE 2'h2
`define ARC_FB_TWO 4'h0
`define ARC_FB_THREE 4'h1
`define ARC_FB_SUM 4'h2
`define ARC_FB_DIFF 4'h3
`define ARC_FB_PROD 4'h4
`define ARC_FB_QUOT 4'h5
`define ARC_FB_MIN 4'h6
`define ARC_FB_MAX 4'h7
`define ARC_FB_SQRT_DIFF 4'h8
`define ARC_FB_SQRT_SPLIT 4'h9
`define ARC_FILT_FRAC 8
`define ARC_SAMPLE_PERIOD_US 1000
`define ARC_US_PER_MS 1000
`endif

// ==== core/arc_conditioner.v ====
// Purpose: filters, scales and combines three analog samples into references
// Assumes: samples arrive as a valid/ready stream on ref_clk (20 MHz)
// Notes: each sample set is processed in two cycles after leaving the FIFO
`timescale 1ns/100ps
`include "arc_defs.vh"

module arc_fifo #(
   parameter WIDTH = 48,
   parameter DEPTH = 8,
   parameter AW = 3
) (
   // Clock and reset
   input wire ref_clk,
   input wire reset,
   // Fill side
   input wire in_valid,
   output reg in_ready,
   input wire [WIDTH-1:0] in_data,
   // Drain side
   output wire out_valid,
   input wire out_ready,
   output wire [WIDTH-1:0] out_data
);
   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [AW-1:0] wr_ptr_reg;
   reg [AW-1:0] rd_ptr_reg;
   reg [AW:0] count_reg;
   reg [AW:0] count_next;
   wire push;
   wire pop;

   assign out_valid = (count_reg != {(AW+1){1'b0}});
   assign out_data = mem[rd_ptr_reg];
   assign push = in_valid & in_ready;
   assign pop = out_valid & out_ready;

   always @* begin
      count_next = count_reg;
      if (push && !pop)
         count_next = count_reg + 1'b1;
      else if (pop && !push)
         count_next = count_reg - 1'b1;
   end

   always @(posedge ref_clk) begin
      if (push)
         mem[wr_ptr_reg] <= in_data;
   end

   always @(posedge ref_clk) begin
      if (reset) begin
         wr_ptr_reg <= {AW{1'b0}};
         rd_ptr_reg <= {AW{1'b0}};
         count_reg <= {(AW+1){1'b0}};
         in_ready <= 1'b0;
      end else begin
         if (push)
            wr_ptr_reg <= (wr_ptr_reg == DEPTH - 1) ? {AW{1'b0}} : wr_ptr_reg + 1'b1;
         if (pop)
            rd_ptr_reg <= (rd_ptr_reg == DEPTH - 1) ? {AW{1'b0}} : rd_ptr_reg + 1'b1;
         count_reg <= count_next;
         in_ready <= (count_next < DEPTH);
      end
   end
endmodule // arc_fifo

module arc_conditioner #(
   parameter SAMPLE_PERIOD_US = `ARC_SAMPLE_PERIOD_US,
   parameter FIFO_DEPTH = 8,
   parameter FIFO_AW = 3
) (
   // Clock and reset
   input wire ref_clk,
   input wire reset,
   // Sample stream
   input wire sample_valid,
   output wire sample_ready,
   input wire [15:0] sample_in1,
   input wire [15:0] sample_in2,
   input wire [15:0] sample_in3,
   // Settings
   input wire [2:0] input1_characteristic_select,
   input wire [2:0] input2_characteristic_select,
   input wire [2:0] input3_characteristic_select,
   input wire [15:0] input_filter_time,
   input wire [1:0] main_channel_select,
   input wire [1:0] auxiliary_channel_select,
   input wire [7:0] auxiliary_adjust_percent,
   input wire [3:0] feedback_calc_select,
   input wire [3:0] frequency_setting_mode,
   input wire [15:0] maximum_frequency_setting,
   input wire tachogenerator_feedback,
   // Results
   output reg signed [16:0] frequency_reference,
   output reg [15:0] loop_reference,
   output reg [15:0] feedback_value,
   output reg result_valid,
   output reg joystick_active,
   output reg auxiliary_active
);
   localparam ST_IDLE = 2'b00;
   localparam ST_FILT = 2'b01;
   localparam ST_CALC = 2'b10;

   reg [1:0] state_reg;
   reg [47:0] hold_reg;
   wire fifo_valid;
   wire [47:0] fifo_data;
   wire [47:0] filt_vec;
   reg [3:0] filt_shift;
   integer k;
   wire [47:0] codes;
   reg abs_all, joy_now, aux_now;
   reg [1:0] aux_sel;
   reg [15:0] main_code, aux_code, main_raw, main_mag, main_frac, aux_frac, joy_mag;
   reg [15:0] fb_a, fb_b, fb_high, loop_out;
   reg signed [16:0] freq_out;
   reg signed [17:0] aux_dev, freq_sum, loop_sum;
   reg signed [55:0] trim_wide, ltrim_wide;
   reg [31:0] main_prod, band, joy_q, fb_calc;

   arc_fifo #(.WIDTH(48), .DEPTH(FIFO_DEPTH), .AW(FIFO_AW)) u_fifo (
      .ref_clk(ref_clk),
      .reset(reset),
      .in_valid(sample_valid),
      .in_ready(sample_ready),
      .in_data({sample_in3, sample_in2, sample_in1}),
      .out_valid(fifo_valid),
      .out_ready(state_reg == ST_IDLE),
      .out_data(fifo_data)
   );

   // Magnitude of a signed sample, saturating at full scale
   function [15:0] mag_of;
      input [15:0] x;
      begin
         if (!x[15])
            mag_of = x;
         else if (x == 16'h8000)
            mag_of = `ARC_FULL_SCALE;
         else
            mag_of = (~x) + 16'h0001;
      end
   endfunction

   // Position of a magnitude within the selected range, 0..FFFF
   function [15:0] frac_of;
      input [15:0] v;
      input [2:0] code;
      reg [17:0] t;
      begin
         t = 18'h00000;
         case (code)
            `ARC_CODE_FULL_FWD, `ARC_CODE_FULL_REV, `ARC_CODE_BIPOLAR:
               t = {1'b0, v, 1'b0};
            `ARC_CODE_HALF_FWD, `ARC_CODE_HALF_REV:
               t = {v, 2'b00};
            `ARC_CODE_OFS_FWD, `ARC_CODE_OFS_REV: begin
               if ({2'b00, v} > `ARC_OFFSET_FLOOR)
                  t = (({2'b00, v} - `ARC_OFFSET_FLOOR) * 18'h00005) >> 1;
            end
            default:
               t = 18'h00000;
         endcase
         if (t > `ARC_FRAC_MAX)
            t = `ARC_FRAC_MAX;
         if (code == `ARC_CODE_FULL_REV || code == `ARC_CODE_HALF_REV ||
             code == `ARC_CODE_OFS_REV)
            frac_of = 16'hFFFF - t[15:0];
         else
            frac_of = t[15:0];
      end
   endfunction

   // Upper limit of a range in sample units
   function [15:0] limit_of;
      input [2:0] code;
      begin
         if (code == `ARC_CODE_HALF_FWD || code == `ARC_CODE_HALF_REV)
            limit_of = `ARC_HALF_SCALE;
         else
            limit_of = `ARC_FULL_SCALE;
      end
   endfunction

   // Unsigned restoring division; a zero divisor saturates
   function [31:0] udiv;
      input [31:0] n;
      input [31:0] d;
      reg [32:0] r;
      reg [31:0] q;
      integer i;
      begin
         r = 33'h000000000;
         q = 32'h00000000;
         for (i = 31; i >= 0; i = i - 1) begin
            r = {r[31:0], n[i]};
            if (r >= {1'b0, d}) begin
               r = r - {1'b0, d};
               q[i] = 1'b1;
            end
         end
         udiv = (d == 32'h00000000) ? 32'hFFFFFFFF : q;
      end
   endfunction

   // Integer square root of a 32-bit value
   function [15:0] isqrt;
      input [31:0] n;
      reg [15:0] root;
      reg [15:0] trial;
      integer i;
      begin
         root = 16'h0000;
         for (i = 15; i >= 0; i = i - 1) begin
            trial = root | (16'h0001 << i);
            if ({16'h0000, trial} * {16'h0000, trial} <= n)
               root = trial;
         end
         isqrt = root;
      end
   endfunction

   // Filter step as a power of two: largest k with period<<k within the time
   always @* begin
      filt_shift = 4'h0;
      for (k = 1; k < 16; k = k + 1) begin
         if ((SAMPLE_PERIOD_US << k) <= input_filter_time * `ARC_US_PER_MS)
            filt_shift = k[3:0];
      end
   end

   genvar g;
   generate
      for (g = 0; g < 3; g = g + 1) begin : g_filt
         wire [15:0] raw = hold_reg[16*g +: 16];
         // Channel two is unipolar: negative codes read as zero
         wire [15:0] x = (g == 1 && raw[15]) ? 16'h0000 : raw;
         wire signed [24:0] err, step;
         reg signed [23:0] y_reg;
         assign err = $signed({x[15], x, 8'h00}) - $signed({y_reg[23], y_reg});
         // One first-order step per sample set; the shift sets the time constant
         assign step = err >>> filt_shift;
         always @(posedge ref_clk) begin
            if (reset)
               y_reg <= 24'h000000;
            else if (state_reg == ST_FILT)
               y_reg <= y_reg + step[23:0];
         end
         assign filt_vec[16*g +: 16] = y_reg[23:8];
      end
   endgenerate

   assign codes = {13'h0000, input3_characteristic_select, 13'h0000,
                   input2_characteristic_select, 13'h0000, input1_characteristic_select};
   // Field of channel one, two or three within a packed triple
   function [15:0] pick;
      input [47:0] vec;
      input [1:0] sel;
      begin
         case (sel)
            2'h1: pick = vec[31:16];
            2'h2: pick = vec[47:32];
            default: pick = vec[15:0];
         endcase
      end
   endfunction

   // Scaling, auxiliary trim, joystick band and feedback arithmetic
   always @* begin
      abs_all = (frequency_setting_mode == `ARC_MODE_ABS_A) ||
                (frequency_setting_mode == `ARC_MODE_ABS_B) || tachogenerator_feedback;
      main_raw = pick(filt_vec, main_channel_select);
      main_code = pick(codes, main_channel_select);
      joy_now = (main_code[2:0] == `ARC_CODE_BIPOLAR) && (main_channel_select != 2'h1);
      aux_now = (auxiliary_channel_select != `ARC_SEL_NONE) && !joy_now;
      aux_sel = (auxiliary_channel_select == `ARC_SEL_THREE) ? 2'h2 : 2'h1;
      aux_code = pick(codes, aux_sel);
      main_mag = (main_raw[15] && !abs_all) ? 16'h0000 : mag_of(main_raw);
      main_frac = frac_of(main_mag, main_code[2:0]);
      main_prod = main_frac * maximum_frequency_setting;
      aux_frac = frac_of(mag_of(pick(filt_vec, aux_sel)), aux_code[2:0]);
      aux_dev = aux_now ? $signed({2'b00, aux_frac}) - $signed(`ARC_FRAC_MID) : 18'sh00000;
      trim_wide = aux_dev * $signed({1'b0, auxiliary_adjust_percent}) *
                  $signed({1'b0, maximum_frequency_setting}) * `ARC_PERMILLE_MUL;
      trim_wide = trim_wide >>> (`ARC_PERMILLE_SHIFT + 15);
      freq_sum = $signed({2'b00, main_prod[31:16]}) + $signed(trim_wide[17:0]);
      ltrim_wide = aux_dev * $signed({1'b0, auxiliary_adjust_percent}) * `ARC_PERMILLE_MUL;
      ltrim_wide = ltrim_wide >>> (`ARC_PERMILLE_SHIFT + 1);
      loop_sum = $signed({3'b000, main_frac[15:1]}) + $signed(ltrim_wide[17:0]);
      // Joystick: band edge to full scale spans zero to maximum frequency
      band = udiv({24'h000000, auxiliary_adjust_percent} * {16'h0000, `ARC_FULL_SCALE},
                  `ARC_PERMILLE_DIV);
      joy_mag = mag_of(main_raw);
      joy_q = 32'h00000000;
      if ({16'h0000, joy_mag} > band)
         joy_q = udiv({16'h0000, joy_mag - band[15:0]} * {16'h0000, maximum_frequency_setting},
                      {16'h0000, `ARC_FULL_SCALE - band[15:0]});
      if (joy_now)
         freq_out = main_raw[15] ? -$signed({1'b0, joy_q[15:0]}) : $signed({1'b0, joy_q[15:0]});
      else if (freq_sum < 18'sh00000)
         freq_out = 17'sh00000;
      else if (freq_sum > $signed({2'b00, maximum_frequency_setting}))
         freq_out = $signed({1'b0, maximum_frequency_setting});
      else
         freq_out = $signed(freq_sum[16:0]);
      loop_out = (loop_sum < 18'sh00000) ? 16'h0000 :
                 (loop_sum > $signed({2'b00, `ARC_FULL_SCALE})) ? `ARC_FULL_SCALE : loop_sum[15:0];
      fb_a = mag_of(filt_vec[31:16]);
      fb_b = mag_of(filt_vec[47:32]);
      fb_high = (limit_of(input2_characteristic_select) > limit_of(input3_characteristic_select)) ?
                limit_of(input2_characteristic_select) : limit_of(input3_characteristic_select);
      case (feedback_calc_select)
         `ARC_FB_TWO: fb_calc = {16'h0000, fb_a};
         `ARC_FB_THREE: fb_calc = {16'h0000, fb_b};
         `ARC_FB_SUM: fb_calc = {16'h0000, fb_a} + {16'h0000, fb_b};
         `ARC_FB_DIFF: fb_calc = (fb_a > fb_b) ? {16'h0000, fb_a - fb_b} : 32'h00000000;
         `ARC_FB_PROD:
            fb_calc = udiv({16'h0000, fb_a} * {16'h0000, fb_b}, {16'h0000, fb_high});
         `ARC_FB_QUOT:
            fb_calc = udiv({16'h0000, fb_a} * {16'h0000, fb_high}, {16'h0000, fb_b});
         `ARC_FB_MIN: fb_calc = (fb_a < fb_b) ? {16'h0000, fb_a} : {16'h0000, fb_b};
         `ARC_FB_MAX: fb_calc = (fb_a > fb_b) ? {16'h0000, fb_a} : {16'h0000, fb_b};
         `ARC_FB_SQRT_DIFF:
            fb_calc = (fb_a > fb_b) ?
               {16'h0000, isqrt({16'h0000, fb_a - fb_b} * {16'h0000, fb_high})} : 32'h00000000;
         `ARC_FB_SQRT_SPLIT:
            fb_calc = (fb_a > fb_b) ? {16'h0000, isqrt({16'h0000, fb_a} * {16'h0000, fb_high}) -
               isqrt({16'h0000, fb_b} * {16'h0000, fb_high})} : 32'h00000000;
         default: fb_calc = 32'h00000000;
      endcase
      if (fb_calc > {16'h0000, fb_high})
         fb_calc = {16'h0000, fb_high};
   end

   // Sequencer: take a sample set, step the filters, register the results
   always @(posedge ref_clk) begin
      if (reset) begin
         state_reg <= ST_IDLE;
         hold_reg <= 48'h000000000000;
         frequency_reference <= 17'h00000;
         loop_reference <= 16'h0000;
         feedback_value <= 16'h0000;
         result_valid <= 1'b0;
         joystick_active <= 1'b0;
         auxiliary_active <= 1'b0;
      end else begin
         result_valid <= 1'b0;
         case (state_reg)
            ST_IDLE: if (fifo_valid) begin
               hold_reg <= fifo_data;
               state_reg <= ST_FILT;
            end
            ST_FILT: state_reg <= ST_CALC;
            ST_CALC: begin
               frequency_reference <= freq_out;
               loop_reference <= loop_out;
               feedback_value <= fb_calc[15:0];
               joystick_active <= joy_now;
               auxiliary_active <= aux_now;
               result_valid <= 1'b1;
               state_reg <= ST_IDLE;
            end
            default: state_reg <= ST_IDLE;
         endcase
      end
   end
endmodule // arc_conditioner

// ==== test/arc_asserts.sv ====
// Purpose: port checker for the conditioner
// Assumes: settings are steady while results are produced
// Notes: bound from tb
`timescale 1ns/100ps
module arc_asserts (
   // Clock, reset and stream
   input wire ref_clk,
   input wire reset,
   input wire sample_valid,
   input wire sample_ready,
   // Settings
   input wire [2:0] input1_characteristic_select,
   input wire [1:0] main_channel_select,
   input wire [1:0] auxiliary_channel_select,
   input wire [15:0] maximum_frequency_setting,
   // Results
   input wire signed [16:0] frequency_reference,
   input wire [15:0] feedback_value,
   input wire result_valid,
   input wire joystick_active,
   input wire auxiliary_active
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (reset);
   sequence s_accept;
      sample_valid && sample_ready;
   endsequence
   sequence s_result;
      ##[1:40] result_valid;
   endsequence
   property p_result;
      s_accept |-> s_result;
   endproperty
   a_result: assert property (p_result) else $error("no result");
   property p_joy;
      result_valid && main_channel_select == 2'h0 && input1_characteristic_select == 3'h6
         |-> joystick_active;
   endproperty
   a_joy: assert property (p_joy) else $error("joystick off");
   property p_joy_aux;
      joystick_active |-> !auxiliary_active;
   endproperty
   a_joy_aux: assert property (p_joy_aux) else $error("aux in joystick");
   property p_aux_off;
      result_valid && auxiliary_channel_select == 2'h0 |-> !auxiliary_active;
   endproperty
   a_aux_off: assert property (p_aux_off) else $error("aux not off");
   property p_aux_on;
      result_valid && auxiliary_channel_select != 2'h0 && !joystick_active |-> auxiliary_active;
   endproperty
   a_aux_on: assert property (p_aux_on) else $error("aux not on");
   property p_fb_max;
      result_valid |-> feedback_value <= 16'h7FFF;
   endproperty
   a_fb_max: assert property (p_fb_max) else $error("feedback over");
   property p_pos;
      result_valid && !joystick_active |-> frequency_reference >= 0;
   endproperty
   a_pos: assert property (p_pos) else $error("negative freq");
   property p_fmax;
      result_valid |-> frequency_reference <= $signed({1'b0, maximum_frequency_setting})
         && frequency_reference >= -$signed({1'b0, maximum_frequency_setting});
   endproperty
   a_fmax: assert property (p_fmax) else $error("freq over max");
endmodule // arc_asserts

// ==== test/arc_regulator_model.sv ====
// Purpose: regulator side that latches each result
// Assumes: results are one-cycle strobes
// Notes: counts results for the buffer test
`timescale 1ns/100ps
module arc_regulator_model (
   // Clock and reset
   input wire ref_clk,
   input wire reset,
   // Results
   input wire result_valid,
   input wire signed [16:0] frequency_reference,
   input wire [15:0] feedback_value,
   // Latched view
   output reg signed [16:0] freq_seen,
   output reg [15:0] fb_seen,
   output integer n_res
);
   always @(posedge ref_clk) begin
      if (reset) begin
         n_res <= 0;
      end else if (result_valid) begin
         freq_seen <= frequency_reference;
         fb_seen <= feedback_value;
         n_res <= n_res + 1;
      end
   end
endmodule // arc_regulator_model

// ==== test/tb.sv ====
// Purpose: self-checking bench of the conditioner
// Assumes: max frequency 50.00 Hz, filter spans three samples
// Notes: values settle over forty samples
`timescale 1ns/100ps
module tb;
   logic ref_clk = 1'b0;
   logic reset = 1'b1;
   logic sample_valid = 1'b0;
   logic [15:0] sample_in1 = 16'h0000, sample_in2 = 16'h0000, sample_in3 = 16'h0000;
   logic [2:0] input1_characteristic_select = 3'h0, input2_characteristic_select = 3'h0;
   logic [2:0] input3_characteristic_select = 3'h0;
   logic [15:0] input_filter_time = 16'h000C, maximum_frequency_setting = 16'h1388;
   logic [1:0] main_channel_select = 2'h0, auxiliary_channel_select = 2'h0;
   logic [7:0] auxiliary_adjust_percent = 8'h00;
   logic [3:0] feedback_calc_select = 4'h0, frequency_setting_mode = 4'h0;
   logic tachogenerator_feedback = 1'b0;
   wire sample_ready, result_valid, joystick_active, auxiliary_active;
   wire signed [16:0] frequency_reference, freq_seen;
   wire [15:0] loop_reference, feedback_value, fb_seen;
   integer n_res, n_fail = 0, check_count = 0, nref = 0, k;
   always #25 ref_clk = ~ref_clk;
   arc_conditioner #(.SAMPLE_PERIOD_US(4000)) i_arc_conditioner (.*);
   arc_regulator_model i_arc_regulator_model (.*);
   task give_verdict;
      begin
         $display("Checks %0d mismatches %0d", check_count, n_fail);
         if (n_fail == 0 && check_count > 0) $display("Testbench passed");
         else $display("Testbench failed");
         $finish;
      end
   endtask
   task chk(input string nm, input integer e, input logic signed [17:0] g, input integer t);
      begin
         check_count = check_count + 1;
         if ((^g === 1'bx) || g < e - t || g > e + t) begin
            n_fail = n_fail + 1;
            $display("Error %s expected %0d seen %0d", nm, e, g);
         end
      end
   endtask
   // Holds valid until n samples are taken, then lets the results drain
   task feed(input logic [15:0] a, b, c, input integer n);
      begin
         sample_in1 <= a;
         sample_in2 <= b;
         sample_in3 <= c;
         sample_valid <= 1'b1;
         k = 0;
         while (k < n) begin
            @(posedge ref_clk);
            if (sample_ready === 1'b1) k = k + 1;
            else nref = nref + 1;
         end
         sample_valid <= 1'b0;
         repeat (60) @(posedge ref_clk);
      end
   endtask
   task t_scale;
      logic [15:0] v [0:5];
      begin
         v = '{16'h4000, 16'h2000, 16'h4000, 16'h2000, 16'h4CCD, 16'h4CCD};
         for (int i = 0; i < 6; i++) begin
            input1_characteristic_select <= i[2:0];
            feed(v[i], 16'h0000, 16'h0000, 40);
            chk("scaled", 2500, freq_seen, 40);
         end
         input1_characteristic_select <= 3'h4;
         feed(16'h0800, 16'h0000, 16'h0000, 40);
         chk("floor", 0, freq_seen, 2);
         input1_characteristic_select <= 3'h0;
         main_channel_select <= 2'h1;
         feed(16'h0000, 16'h7FFF, 16'h0000, 40);
         chk("main two", 5000, freq_seen, 40);
         main_channel_select <= 2'h2;
         feed(16'h0000, 16'h0000, 16'h1999, 40);
         chk("main three", 1000, freq_seen, 40);
         main_channel_select <= 2'h0;
         $display("t_scale done");
      end
   endtask
   task t_joy;
      begin
         input1_characteristic_select <= 3'h6;
         auxiliary_adjust_percent <= 8'hC8;
         auxiliary_channel_select <= 2'h1;
         feed(16'h1000, 16'h7FFF, 16'h0000, 40);
         chk("band", 0, freq_seen, 2);
         chk("joystick", 1, joystick_active, 0);
         chk("aux", 0, auxiliary_active, 0);
         feed(16'hC000, 16'h7FFF, 16'h0000, 40);
         chk("joy rev", -1875, freq_seen, 40);
         input1_characteristic_select <= 3'h0;
         $display("t_joy done");
      end
   endtask
   task t_aux;
      begin
         feed(16'h4000, 16'h0000, 16'h0000, 40);
         chk("aux low", 1500, freq_seen, 40);
         chk("loop ref", 13107, loop_reference, 40);
         feed(16'h4000, 16'h7FFF, 16'h0000, 40);
         chk("aux high", 3500, freq_seen, 40);
         chk("aux on", 1, auxiliary_active, 0);
         auxiliary_channel_select <= 2'h0;
         auxiliary_adjust_percent <= 8'h00;
         $display("t_aux done");
      end
   endtask
   task t_abs;
      begin
         for (int m = 7; m < 10; m++) begin
            frequency_setting_mode <= (m == 9) ? 4'h0 : m[3:0];
            tachogenerator_feedback <= (m == 9);
            feed(16'hC000, 16'h0000, 16'h0000, 40);
            chk("absolute", 2500, freq_seen, 40);
         end
         tachogenerator_feedback <= 1'b0;
         $display("t_abs done");
      end
   endtask
   task t_fb;
      integer e [0:9];
      begin
         e = '{16384, 8192, 24576, 8192, 4096, 32767, 8192, 16384, 16383, 6786};
         for (int i = 0; i < 10; i++) begin
            feedback_calc_select <= i[3:0];
            feed(16'h0000, 16'h4000, 16'h2000, 40);
            chk("feedback", e[i], fb_seen, 40);
         end
         $display("t_fb done");
      end
   endtask
   task t_fifo;
      integer r;
      begin
         nref = 0;
         r = n_res;
         feed(16'h4000, 16'h0000, 16'h0000, 24);
         chk("refused", 1, nref > 0, 0);
         chk("results", r + 24, n_res, 0);
         $display("t_fifo done");
      end
   endtask
   initial begin
      repeat (6) @(posedge ref_clk);
      reset <= 1'b0;
      @(posedge ref_clk);
      t_scale;
      t_joy;
      t_aux;
      t_abs;
      t_fb;
      t_fifo;
      give_verdict;
   end
   initial begin
      #2000000;
      n_fail = n_fail + 1;
      give_verdict;
   end
endmodule // tb
bind arc_conditioner arc_asserts i_arc_asserts (.*);
